// ==== rtl/dcdm_consts.vh ====
// Purpose: constants for the drive cyclic data mapper
// Assumes: 16-byte telegrams each way, byte 0 first
// Notes: header only, no logic
`ifndef DCDM_CONSTS_VH
`define DCDM_CONSTS_VH
`define DCDM_TG_BYTES 16
`define DCDM_TG_BITS 128
`define DCDM_MODE_POS 8'h01
`define DCDM_MODE_VEL 8'h03
`define DCDM_MODE_CUR 8'h04
`define DCDM_MODE_HOME 8'h06
// state codes, one-hot
`define DCDM_ST_NRDY 8'h01
`define DCDM_ST_SOD 8'h02
`define DCDM_ST_RSO 8'h04
`define DCDM_ST_SON 8'h08
`define DCDM_ST_OPEN 8'h10
`define DCDM_ST_QSA 8'h20
`define DCDM_ST_FRA 8'h40
`define DCDM_ST_FLT 8'h80
// state report bits 6,5,3,2,1,0 per state
`define DCDM_SW_NRDY 16'h0000
`define DCDM_SW_SOD 16'h0040
`define DCDM_SW_RSO 16'h0021
`define DCDM_SW_SON 16'h0023
`define DCDM_SW_OPEN 16'h0027
`define DCDM_SW_QSA 16'h0007
`define DCDM_SW_FRA 16'h000F
`define DCDM_SW_FLT 16'h0008
`define DCDM_SW_VOLT 16'h0010
`define DCDM_SW_REMOTE 16'h0200
`define DCDM_SW_LIMIT 16'h0800
`define DCDM_CW_SON 0
`define DCDM_CW_EV 1
`define DCDM_CW_QS 2
`define DCDM_CW_EO 3
`define DCDM_CW_FRST 7
// controller telegram field positions
`define DCDM_OT_CW_LSB 0
`define DCDM_OT_CW_MSB 15
`define DCDM_OT_MODE_LSB 16
`define DCDM_OT_MODE_MSB 23
`define DCDM_OT_HM_LSB 24
`define DCDM_OT_HM_MSB 31
`define DCDM_OT_SP_LSB 32
`define DCDM_OT_SP16_MSB 47
`define DCDM_OT_SP32_MSB 63
`define DCDM_OT_LIM_LSB 64
`define DCDM_OT_LIM_MSB 79
// drive telegram field positions
`define DCDM_IT_SW_LSB 0
`define DCDM_IT_SW_MSB 15
`define DCDM_IT_MODE_LSB 16
`define DCDM_IT_MODE_MSB 23
`define DCDM_IT_ACT_LSB 24
`define DCDM_IT_ACT16_MSB 39
`define DCDM_IT_ACT32_MSB 55
`define DCDM_IT_CONS_LSB 64
`define DCDM_IT_CONS_MSB 79
`define DCDM_SW_TGT_BIT 10
`define DCDM_LIMIT_OFF 16'h0000
`endif

// ==== rtl/dcdm_state_machine.v ====
// Purpose: drive state machine stepped by command word and faults
// Assumes: fault and local command inputs synchronous to ref_clk
// Notes: leaves after reset through not-ready to switch-on-disabled
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.vh"
module dcdm_state_machine (
  input wire ref_clk, // clock
  input wire rst_b, // async reset, low
  input wire [15:0] cmd_word, // active command word
  input wire bus_volt_ok, // dc bus voltage good
  input wire fault_det, // internal error detected
  input wire stop_done, // fault ramp-down finished
  output reg [7:0] state_reg // one-hot state
);
  localparam [7:0] ST_NRDY = `DCDM_ST_NRDY;
  localparam [7:0] ST_SOD = `DCDM_ST_SOD;
  localparam [7:0] ST_RSO = `DCDM_ST_RSO;
  localparam [7:0] ST_SON = `DCDM_ST_SON;
  localparam [7:0] ST_OPEN = `DCDM_ST_OPEN;
  localparam [7:0] ST_QSA = `DCDM_ST_QSA;
  localparam [7:0] ST_FRA = `DCDM_ST_FRA;
  localparam [7:0] ST_FLT = `DCDM_ST_FLT;
  reg [7:0] state_next;
  wire son = cmd_word[`DCDM_CW_SON];
  wire ev = cmd_word[`DCDM_CW_EV];
  wire qs = cmd_word[`DCDM_CW_QS];
  wire eo = cmd_word[`DCDM_CW_EO];
  wire frst = cmd_word[`DCDM_CW_FRST];
  // commands only move the state where the state allows them
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_NRDY: state_next = ST_SOD;
      ST_SOD:
        if (ev && qs && !son && bus_volt_ok)
          state_next = ST_RSO;
      ST_RSO:
        if (!ev || !qs) state_next = ST_SOD;
        else if (son) state_next = ST_SON;
      ST_SON:
        if (!ev || !qs) state_next = ST_SOD;
        else if (!son) state_next = ST_RSO;
        else if (eo) state_next = ST_OPEN;
      ST_OPEN:
        if (!ev) state_next = ST_SOD;
        else if (!qs) state_next = ST_QSA;
        else if (!son) state_next = ST_RSO;
        else if (!eo) state_next = ST_SON;
      ST_QSA:
        if (!ev) state_next = ST_SOD;
      ST_FRA:
        if (stop_done) state_next = ST_FLT;
      ST_FLT:
        if (frst && !fault_det) state_next = ST_SOD;
      default: state_next = ST_NRDY;
    endcase
    // faults override any command
    if (fault_det && state_reg != ST_FRA && state_reg != ST_FLT)
      state_next = ST_FRA;
  end
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= ST_NRDY;
    else
      state_reg <= state_next;
  end
endmodule
`default_nettype wire

// ==== rtl/dcdm_mapper.v ====
// Purpose: map cyclic 16-byte telegrams to drive fields and back
// Assumes: out_valid marks one complete controller telegram
// Assumes: net_ok low hands the command word to local_cmd
// Notes: byte n of a telegram sits at bits 8n+7:8n, words little endian
// Notes: in_tg_reg is rebuilt every cycle, so the reply beside in_valid_reg
// Notes: still carries the layout of the mode in force before that telegram
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.vh"
module dcdm_mapper (
  input wire ref_clk, // 50 MHz clock
  input wire rst_b, // async reset, low
  input wire [127:0] out_tg, // controller telegram, 16 bytes
  input wire out_valid, // pulse: out_tg complete
  input wire net_ok, // network link healthy
  input wire [15:0] local_cmd, // local command word
  input wire bus_volt_ok, // dc bus voltage good
  input wire fault_det, // internal error detected
  input wire stop_done, // fault ramp-down finished
  input wire target_reached, // motion target reached
  input wire signed [31:0] act_pos, // measured position
  input wire signed [31:0] act_vel, // measured velocity
  input wire signed [15:0] act_cur, // measured current
  input wire signed [15:0] cur_cons, // current consumption, per-mille
  output reg [127:0] in_tg_reg, // drive telegram, 16 bytes
  output reg in_valid_reg, // pulse: in_tg fresh
  output reg [7:0] operating_mode_select, // active mode code
  output reg [7:0] homing_method_reg, // homing method, homing mode only
  output reg signed [31:0] target_pos_reg, // position setpoint
  output reg signed [31:0] target_vel_reg, // velocity setpoint
  output reg signed [15:0] target_cur_reg, // current setpoint
  output reg signed [15:0] cur_limit_reg, // applied current limit
  output reg cur_limit_en_reg, // current limitation active
  output reg motion_en_reg, // moves allowed
  output reg [7:0] drive_state_reg // one-hot drive state
);
  // ****************************************
  // state names
  // ****************************************
  // same one-hot codes as inside the state machine
  localparam [7:0] ST_NRDY = `DCDM_ST_NRDY;
  localparam [7:0] ST_SOD = `DCDM_ST_SOD;
  localparam [7:0] ST_RSO = `DCDM_ST_RSO;
  localparam [7:0] ST_SON = `DCDM_ST_SON;
  localparam [7:0] ST_OPEN = `DCDM_ST_OPEN;
  localparam [7:0] ST_QSA = `DCDM_ST_QSA;
  localparam [7:0] ST_FRA = `DCDM_ST_FRA;
  localparam [7:0] ST_FLT = `DCDM_ST_FLT;
  // ****************************************
  // command capture
  // ****************************************
  reg [15:0] net_cmd_reg;
  // a dead network hands over to the local panel instead of freezing the drive
  wire [15:0] cmd_word = net_ok ? net_cmd_reg : local_cmd;
  // controller fields; bytes 10-15 are never read
  wire [15:0] rx_cw = out_tg[`DCDM_OT_CW_MSB:`DCDM_OT_CW_LSB];
  wire [7:0] rx_mode = out_tg[`DCDM_OT_MODE_MSB:`DCDM_OT_MODE_LSB];
  wire [7:0] rx_homing = out_tg[`DCDM_OT_HM_MSB:`DCDM_OT_HM_LSB];
  wire [31:0] rx_sp32 = out_tg[`DCDM_OT_SP32_MSB:`DCDM_OT_SP_LSB];
  wire [15:0] rx_sp16 = out_tg[`DCDM_OT_SP16_MSB:`DCDM_OT_SP_LSB];
  wire [15:0] rx_limit = out_tg[`DCDM_OT_LIM_MSB:`DCDM_OT_LIM_LSB];
  // zero switches limitation off, it never clamps the current to zero
  wire rx_limit_on = (rx_limit != `DCDM_LIMIT_OFF);
  wire [7:0] state;
  // everything taken from the controller lands on one out_valid edge
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      net_cmd_reg <= 16'h0000;
      operating_mode_select <= 8'h00;
      homing_method_reg <= 8'h00;
      target_pos_reg <= 32'h00000000;
      target_vel_reg <= 32'h00000000;
      target_cur_reg <= 16'h0000;
      cur_limit_reg <= 16'h0000;
      cur_limit_en_reg <= 1'b0;
    end
    else if (out_valid)
    begin
      net_cmd_reg <= rx_cw;
      operating_mode_select <= rx_mode;
      cur_limit_reg <= rx_limit;
      cur_limit_en_reg <= rx_limit_on;
      if (rx_mode == `DCDM_MODE_HOME)
        homing_method_reg <= rx_homing;
      // setpoints of the other modes keep their last value
      case (rx_mode)
        `DCDM_MODE_POS:
        begin
          target_pos_reg <= rx_sp32;
        end
        `DCDM_MODE_VEL:
        begin
          target_vel_reg <= rx_sp32;
        end
        `DCDM_MODE_CUR:
        begin
          target_cur_reg <= rx_sp16;
        end
        default: ;
      endcase
    end
  end
  // ****************************************
  // drive state machine
  // ****************************************
  dcdm_state_machine u_fsm (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .cmd_word(cmd_word),
    .bus_volt_ok(bus_volt_ok),
    .fault_det(fault_det),
    .stop_done(stop_done),
    .state_reg(state)
  );
  // ****************************************
  // state report word
  // ****************************************
  // bits 0-3, 5 and 6 carry the state, the rest are flags
  reg [15:0] sw;
  always @*
  begin
    case (state)
      ST_NRDY: sw = `DCDM_SW_NRDY;
      ST_SOD: sw = `DCDM_SW_SOD;
      ST_RSO: sw = `DCDM_SW_RSO;
      ST_SON: sw = `DCDM_SW_SON;
      ST_OPEN: sw = `DCDM_SW_OPEN;
      ST_QSA: sw = `DCDM_SW_QSA;
      ST_FRA: sw = `DCDM_SW_FRA;
      ST_FLT: sw = `DCDM_SW_FLT;
      default: sw = `DCDM_SW_NRDY;
    endcase
    // warning and reserved bits stay zero
    if (bus_volt_ok)
      sw = sw | `DCDM_SW_VOLT;
    // remote shows which side owns the command word
    if (net_ok)
      sw = sw | `DCDM_SW_REMOTE;
    if (cur_limit_en_reg)
      sw = sw | `DCDM_SW_LIMIT;
    sw[`DCDM_SW_TGT_BIT] = target_reached;
  end
  // ****************************************
  // input telegram build
  // ****************************************
  reg [127:0] tg;
  always @*
  begin
    // spare bytes and unused parts of a layout go out as zero
    tg = {`DCDM_TG_BITS{1'b0}};
    tg[`DCDM_IT_SW_MSB:`DCDM_IT_SW_LSB] = sw;
    tg[`DCDM_IT_MODE_MSB:`DCDM_IT_MODE_LSB] = operating_mode_select;
    case (operating_mode_select)
      `DCDM_MODE_POS:
      begin
        tg[`DCDM_IT_ACT32_MSB:`DCDM_IT_ACT_LSB] = act_pos;
      end
      `DCDM_MODE_VEL:
      begin
        tg[`DCDM_IT_ACT32_MSB:`DCDM_IT_ACT_LSB] = act_vel;
      end
      `DCDM_MODE_CUR:
      begin
        tg[`DCDM_IT_ACT16_MSB:`DCDM_IT_ACT_LSB] = act_cur;
      end
      // homing and unknown modes report only the common fields
      default: ;
    endcase
    tg[`DCDM_IT_CONS_MSB:`DCDM_IT_CONS_LSB] = cur_cons;
  end
  // refreshed every cycle so local operation stays visible
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_tg_reg <= {`DCDM_TG_BITS{1'b0}};
      in_valid_reg <= 1'b0;
    end
    else
    begin
      in_tg_reg <= tg;
      in_valid_reg <= out_valid;
    end
  end
  // ****************************************
  // state outputs
  // ****************************************
  // registered beside in_tg_reg so both show the same state in one cycle
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      motion_en_reg <= 1'b0;
      drive_state_reg <= ST_NRDY;
    end
    else
    begin
      // quick stop keeps the power stage on but must not start moves
      motion_en_reg <= (state == ST_OPEN);
      drive_state_reg <= state;
    end
  end
endmodule
`default_nettype wire

// ==== bench/dcdm_mapper_checker.sv ====
// Purpose: port assertions for the cyclic data mapper
// Assumes: mode codes 3,4,6 and one-hot states as handed over
// Notes: bound into every dcdm_mapper
`timescale 1ns/1ps
`default_nettype none
module dcdm_mapper_checker (
  input wire ref_clk, // clock
  input wire rst_b, // reset, low
  input wire [127:0] out_tg, // from controller
  input wire out_valid, // telegram strobe
  input wire fault_det, // fault in
  input wire [15:0] act_cur, // current in
  input wire [15:0] cur_cons, // consumption in
  input wire [127:0] in_tg_reg, // to controller
  input wire in_valid_reg, // reply strobe
  input wire [7:0] operating_mode_select, // mode
  input wire [7:0] homing_method_reg, // homing method
  input wire [31:0] target_vel_reg, // velocity
  input wire [15:0] cur_limit_reg, // limit
  input wire cur_limit_en_reg, // limit on
  input wire [7:0] drive_state_reg // state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // fault ramp-down must start within a few edges
  sequence s_ramp;
    ##[1:3] drive_state_reg == 8'h40;
  endsequence
  a_reply_strobe: assert property (out_valid |=> in_valid_reg) else $error("no reply strobe");
  a_limit_off: assert property (out_valid && out_tg[79:64] == 16'h0000 |=> !cur_limit_en_reg)
    else $error("zero limit not off");
  a_limit_take: assert property (out_valid && out_tg[79:64] != 16'h0000 |=> cur_limit_en_reg &&
    cur_limit_reg == $past(out_tg[79:64])) else $error("limit not taken");
  a_vel_layout: assert property (out_valid && out_tg[23:16] == 8'h03 |=> operating_mode_select == 8'h03 &&
    target_vel_reg == $past(out_tg[63:32])) else $error("velocity layout");
  a_cur_echo: assert property (operating_mode_select == 8'h04 && !out_valid |=> in_tg_reg[23:16] == 8'h04 &&
    in_tg_reg[39:24] == $past(act_cur) && in_tg_reg[63:40] == 24'h000000) else $error("current echo");
  a_cons_spare: assert property (rst_b |=> in_tg_reg[79:64] == $past(cur_cons) &&
    in_tg_reg[127:80] == 48'h0) else $error("consumption or spare");
  a_open_bits: assert property (drive_state_reg == 8'h10 |-> (in_tg_reg[15:0] & 16'h006F) == 16'h0027)
    else $error("state bits");
  a_fault_ramp: assert property (fault_det && drive_state_reg == 8'h10 |-> s_ramp) else $error("no ramp");
  a_homing_hold: assert property (out_valid && out_tg[23:16] != 8'h06 |=> $stable(homing_method_reg))
    else $error("homing taken");
endmodule
bind dcdm_mapper dcdm_mapper_checker chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .out_tg(out_tg),
  .out_valid(out_valid), .fault_det(fault_det), .act_cur(act_cur), .cur_cons(cur_cons), .in_tg_reg(in_tg_reg),
  .in_valid_reg(in_valid_reg), .operating_mode_select(operating_mode_select),
  .homing_method_reg(homing_method_reg), .target_vel_reg(target_vel_reg), .cur_limit_reg(cur_limit_reg),
  .cur_limit_en_reg(cur_limit_en_reg), .drive_state_reg(drive_state_reg));
`default_nettype wire

// ==== bench/dcdm_plc_model.sv ====
// Purpose: controller side, sends one 16-byte telegram per go
// Assumes: go is a one-cycle request
// Notes: data toggles between telegrams so stale bytes are useless
`timescale 1ns/1ps
`default_nettype none
module dcdm_plc_model (
  input wire ref_clk, // clock
  input wire go, // send request
  input wire [15:0] cw, // command word
  input wire [7:0] mode, // mode code
  input wire [7:0] hm, // homing method
  input wire [31:0] sp, // setpoint
  input wire [15:0] lim, // current limit
  output logic [127:0] out_tg, // telegram
  output logic out_valid // strobe
);
  initial out_tg = 128'h0;
  always @(posedge ref_clk)
  begin
    out_valid <= go;
    if (go)
      out_tg <= {48'h0, lim, sp, hm, mode, cw};
    else
      out_tg <= ~out_tg;
  end
endmodule
`default_nettype wire

// ==== bench/test_drive_cyclic_data_mapper.sv ====
// Purpose: self-checking bench for the cyclic data mapper
// Assumes: 50 MHz clock, timing as handed over
// Notes: net_ok drops at the end so local_cmd steers the drive
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_drive_cyclic_data_mapper;
  logic ref_clk = 0, rst_b = 0, go = 0, fault_det = 0, stop_done = 0, out_valid;
  logic [15:0] cw = 0, lim = 0;
  logic [7:0] mode = 0, hm = 0;
  logic [31:0] sp = 0;
  logic [127:0] out_tg, in_tg;
  logic [7:0] om, hmr, st;
  logic [31:0] tv;
  logic [15:0] tc, cl;
  logic cle, men;
  logic [31:0] tp;
  logic net_ok = 1'b1;
  logic [15:0] local_cmd = 16'h0000, ac = 16'h1234;
  int fails = 0, samples_checked = 0;
  always #10 ref_clk = ~ref_clk;
  dcdm_plc_model plc_u (.ref_clk(ref_clk), .go(go), .cw(cw), .mode(mode), .hm(hm), .sp(sp), .lim(lim),
    .out_tg(out_tg), .out_valid(out_valid));
  dcdm_mapper dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .out_tg(out_tg), .out_valid(out_valid), .net_ok(net_ok),
    .local_cmd(local_cmd), .bus_volt_ok(1'b1), .fault_det(fault_det), .stop_done(stop_done),
    .target_reached(1'b0), .act_pos(32'h0), .act_vel(32'h0), .act_cur(ac), .cur_cons(16'h03E8),
    .in_tg_reg(in_tg), .in_valid_reg(), .operating_mode_select(om), .homing_method_reg(hmr),
    .target_pos_reg(tp), .target_vel_reg(tv), .target_cur_reg(tc), .cur_limit_reg(cl),
    .cur_limit_en_reg(cle), .motion_en_reg(men), .drive_state_reg(st));
  task summarize;
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // waits out telegram, take, state step and report
  task send(input [15:0] c, input [7:0] m, input [7:0] h, input [31:0] s, input [15:0] l);
    @(posedge ref_clk);
    cw <= c;
    mode <= m;
    hm <= h;
    sp <= s;
    lim <= l;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask
  task state(input [7:0] s, input [15:0] w);
    `CHK("state", s, st)
    `CHK("report", w, in_tg[15:0] & 16'h006F)
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    send(16'h000F, 8'h03, 8'h00, 32'h0, 16'h0);
    state(8'h02, 16'h0040);
    send(16'h0006, 8'h03, 8'h00, 32'h80000001, 16'h0);
    state(8'h04, 16'h0021);
    `CHK("vel", 32'h80000001, tv)
    `CHK("lim_en", 1'b0, cle)
    `CHK("pos", 32'h0, tp)
    send(16'h0007, 8'h03, 8'h00, 32'h5, 16'h01F4);
    state(8'h08, 16'h0023);
    `CHK("lim", 16'h01F4, cl)
    send(16'h000F, 8'h04, 8'h11, 32'h0000FF38, 16'h01F4);
    state(8'h10, 16'h0027);
    `CHK("motion", 1'b1, men)
    `CHK("cur", 16'hFF38, tc)
    `CHK("echo", 24'h123404, in_tg[39:16])
    `CHK("cons", 16'h03E8, in_tg[79:64])
    `CHK("homing", 8'h00, hmr)
    send(16'h000F, 8'h06, 8'h22, 32'h0, 16'h0);
    `CHK("homing", 8'h22, hmr)
    @(posedge ref_clk);
    fault_det <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    state(8'h40, 16'h000F);
    @(posedge ref_clk);
    stop_done <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    state(8'h80, 16'h0008);
    @(posedge ref_clk);
    fault_det <= 1'b0;
    send(16'h0080, 8'h03, 8'h00, 32'h0, 16'h0);
    state(8'h02, 16'h0040);
    @(posedge ref_clk);
    net_ok <= 1'b0;
    local_cmd <= 16'h0006;
    repeat (4) @(posedge ref_clk);
    #1;
    state(8'h04, 16'h0021);
    `CHK("remote", 1'b0, in_tg[9])
    summarize;
  end
  initial
  begin
    #20000;
    fails++;
    summarize;
  end
endmodule
`default_nettype wire
